// >>> gpio_mux_pkg.sv
package gpio_mux_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [9:0] DIR_OFS = 10'h06e;
  localparam logic [9:0] ISEL2_OFS = 10'h06f;
  localparam logic [9:0] ISEL1_OFS = 10'h070;
  localparam logic [9:0] ISEL0_OFS = 10'h071;
  localparam logic [9:0] OSEL2_OFS = 10'h072;
  localparam logic [9:0] OSEL1_OFS = 10'h073;
  localparam logic [9:0] OSEL0_OFS = 10'h074;
  localparam logic [9:0] RSVD_OFS = 10'h075;
  localparam logic [9:0] OVAL_OFS = 10'h076;
  localparam logic [9:0] RDBK_OFS = 10'h219;
  // ------------------------------------------------------------
  // reset values and function codes
  // ------------------------------------------------------------
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [2:0] FN_GENERAL = 3'h0;
  localparam logic [2:0] FN_SEL_A = 3'h1;
  localparam logic [2:0] FN_SEL_B = 3'h2;
  localparam logic [2:0] FN_REF_SEL = 3'h5;
  localparam int PINS = 4;
  localparam int CLK_OUTS = 8;

  // status flags from the pll and reference monitors
  typedef struct packed {
    logic [1:0] lossOfLock;
    logic [1:0] holdover;
    logic [1:0] lossOfSignal;
  } status_flags_t;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // manual reference select outputs
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] active;
  } ref_select_t;
endpackage

// >>> clock_chip_gpio_mux.sv
// Functional notes
// - each pin has a direction bit, 0 input 1 output, reset to input
// - general-input pin levels readable at 0x219 in a four-bit register
// - input code 000 copies the pin level into its readback bit
// - pin 0 input codes 001/010 gate clock outputs 0 and 4
// - pin 1 input codes 001/010 gate clock outputs 1 and 5
// - pin 2 input codes 001/010 gate clock outputs 2 and 6
// - pin 2 input code 101 drives manual reference select of first pll
// - pin 3 input codes 001/010 gate clock outputs 3 and 7
// - pin 3 input code 101 drives manual reference select of second pll
// - output code 000 drives the pin from the output value register
// - pin 0 output codes 001/010 drive loss-of-lock of pll one/two
// - pin 1 output codes 001/010 drive holdover of pll one/two
// - pin 2 output codes 001/010 drive loss-of-signal of ref 0/1
// - pin 3 output codes 001/010 drive loss-of-lock pll two, los ref 1
// - output value register resets to zero, used only for general output
// - reserved bits are written zero, writes accepted, reads not relied on
// - register enable 0 puts a clock output in high impedance
//
// Strobed register access is this design's own decision.
module clock_chip_gpio_mux (
  input wire logic core_clk,
  input wire logic resetn,
  input wire gpio_mux_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  input wire logic [3:0] gpioIn,
  output logic [3:0] gpioOut,
  output logic [3:0] gpioOe,
  input wire gpio_mux_pkg::status_flags_t statusFlags,
  input wire logic [7:0] outEnableReg,
  output logic [7:0] clockOutputEnable,
  output gpio_mux_pkg::ref_select_t refSelect
);
  import gpio_mux_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] isel2;
    logic [3:0] isel1;
    logic [3:0] isel0;
    logic [3:0] osel2;
    logic [3:0] osel1;
    logic [3:0] osel0;
    logic [3:0] outVal;
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] readback;
    logic [7:0] rdata;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
    logic [7:0] clkEn;
    logic [1:0] refLevel;
    logic [1:0] refActive;
  } state_t;

  state_t s_q;
  state_t s_d;

  // field of one pin across the three code registers
  function automatic logic [2:0] code(input logic [3:0] b2, input logic [3:0] b1,
                                      input logic [3:0] b0, input int p);
    code = {b2[p], b1[p], b0[p]};
  endfunction

  // status flag selected by an output code for one pin
  function automatic logic flagFor(input int p, input logic [2:0] c,
                                   input status_flags_t f);
    flagFor = 1'b0;
    if (c == FN_SEL_A) begin
      case (p)
        0: flagFor = f.lossOfLock[0];
        1: flagFor = f.holdover[0];
        2: flagFor = f.lossOfSignal[0];
        default: flagFor = f.lossOfLock[1];
      endcase
    end else if (c == FN_SEL_B) begin
      case (p)
        0: flagFor = f.lossOfLock[1];
        1: flagFor = f.holdover[1];
        default: flagFor = f.lossOfSignal[1];
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [2:0] ic;
    logic [2:0] oc;
    logic [7:0] gate;
    ic = FN_GENERAL;
    oc = FN_GENERAL;
    gate = 8'hff;
    s_d = s_q;
    // register writes, upper reserved bits dropped
    if (regReq.wr) begin
      case (regReq.addr)
        DIR_OFS: s_d.dir = regReq.wdata[3:0];
        ISEL2_OFS: s_d.isel2 = regReq.wdata[3:0];
        ISEL1_OFS: s_d.isel1 = regReq.wdata[3:0];
        ISEL0_OFS: s_d.isel0 = regReq.wdata[3:0];
        OSEL2_OFS: s_d.osel2 = regReq.wdata[3:0];
        OSEL1_OFS: s_d.osel1 = regReq.wdata[3:0];
        OSEL0_OFS: s_d.osel0 = regReq.wdata[3:0];
        OVAL_OFS: s_d.outVal = regReq.wdata[3:0];
        default: s_d.outVal = s_q.outVal;
      endcase
    end
    // two-stage synchroniser on the pin levels
    s_d.syncA = gpioIn;
    s_d.syncB = s_q.syncA;
    // read data, stands one cycle after the strobe only
    s_d.rdata = 8'h00;
    if (regReq.rd) begin
      case (regReq.addr)
        DIR_OFS: s_d.rdata = {4'h0, s_q.dir};
        ISEL2_OFS: s_d.rdata = {4'h0, s_q.isel2};
        ISEL1_OFS: s_d.rdata = {4'h0, s_q.isel1};
        ISEL0_OFS: s_d.rdata = {4'h0, s_q.isel0};
        OSEL2_OFS: s_d.rdata = {4'h0, s_q.osel2};
        OSEL1_OFS: s_d.rdata = {4'h0, s_q.osel1};
        OSEL0_OFS: s_d.rdata = {4'h0, s_q.osel0};
        OVAL_OFS: s_d.rdata = {4'h0, s_q.outVal};
        RDBK_OFS: s_d.rdata = {4'h0, s_q.readback};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // per-pin function decode
    s_d.refLevel = 2'b00;
    s_d.refActive = 2'b00;
    for (int p = 0; p < PINS; p++) begin
      ic = code(s_q.isel2, s_q.isel1, s_q.isel0, p);
      oc = code(s_q.osel2, s_q.osel1, s_q.osel0, p);
      s_d.readback[p] = 1'b0;
      s_d.pinOe[p] = s_q.dir[p];
      s_d.pinOut[p] = 1'b0;
      if (s_q.dir[p]) begin
        if (oc == FN_GENERAL) begin
          s_d.pinOut[p] = s_q.outVal[p];
        end else begin
          s_d.pinOut[p] = flagFor(p, oc, statusFlags);
        end
      end else begin
        if (ic == FN_GENERAL) begin
          s_d.readback[p] = s_q.syncB[p];
        end else if (ic == FN_SEL_A) begin
          gate[p] = s_q.syncB[p];
        end else if (ic == FN_SEL_B) begin
          gate[p+4] = s_q.syncB[p];
        end else if (ic == FN_REF_SEL && p >= 2) begin
          // bit 0 of the pin index picks the pll, so no negative index
          s_d.refLevel[p[0]] = s_q.syncB[p];
          s_d.refActive[p[0]] = 1'b1;
        end
      end
    end
    // register enable and pin gating are ANDed, either one low turns an output off
    s_d.clkEn = outEnableReg & gate;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign regRdata = s_q.rdata;
  assign gpioOut = s_q.pinOut;
  assign gpioOe = s_q.pinOe;
  assign clockOutputEnable = s_q.clkEn;
  assign refSelect = '{level: s_q.refLevel, active: s_q.refActive};

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // per-pin codes as the decode reads them
  logic [2:0] pin0In;
  logic [2:0] pin0Out;
  logic [2:0] pin2In;
  logic [2:0] pin1In;
  logic [2:0] pin3In;
  logic [2:0] pin1Out;
  logic [2:0] pin2Out;
  logic [2:0] pin3Out;
  assign pin0In = {s_q.isel2[0], s_q.isel1[0], s_q.isel0[0]};
  assign pin0Out = {s_q.osel2[0], s_q.osel1[0], s_q.osel0[0]};
  assign pin2In = {s_q.isel2[2], s_q.isel1[2], s_q.isel0[2]};
  assign pin1In = {s_q.isel2[1], s_q.isel1[1], s_q.isel0[1]};
  assign pin3In = {s_q.isel2[3], s_q.isel1[3], s_q.isel0[3]};
  assign pin1Out = {s_q.osel2[1], s_q.osel1[1], s_q.osel0[1]};
  assign pin2Out = {s_q.osel2[2], s_q.osel1[2], s_q.osel0[2]};
  assign pin3Out = {s_q.osel2[3], s_q.osel1[3], s_q.osel0[3]};

  dir_write_a: assert property (
    regReq.wr && regReq.addr == DIR_OFS |-> ##2 gpioOe == $past(regReq.wdata[3:0], 2))
    else $error("pin enable does not follow direction write");
  readback_read_a: assert property (
    regReq.rd && regReq.addr == RDBK_OFS |=> regRdata == {4'h0, $past(s_q.readback)})
    else $error("readback register read wrong");
  sync_path_a: assert property (
    $past(resetn, 2) && $past(resetn) && !s_q.dir[1] && $stable(s_q.dir)
    && $stable(s_q.isel0) && s_q.isel0[1] == 1'b0
    && s_q.isel1[1] == 1'b0 && s_q.isel2[1] == 1'b0 |=> s_q.readback[1] == $past(gpioIn[1], 3))
    else $error("general input not reflected after sync");
  oe_map_a: assert property (
    !s_q.dir[0] && pin0In == FN_SEL_B |=> clockOutputEnable[4] ==
    ($past(outEnableReg[4]) & $past(s_q.syncB[0])))
    else $error("pin 0 does not gate clock output 4");
  ref_first_a: assert property (
    !s_q.dir[2] && pin2In == FN_REF_SEL |=> refSelect.active[0] &&
    refSelect.level[0] == $past(s_q.syncB[2]))
    else $error("first reference select not routed");
  gp_output_a: assert property (
    s_q.dir[0] && pin0Out == FN_GENERAL |=> gpioOut[0] == $past(s_q.outVal[0]))
    else $error("general output value not driven");
  lol_output_a: assert property (
    s_q.dir[0] && pin0Out == FN_SEL_B |=> gpioOut[0] == $past(statusFlags.lossOfLock[1]))
    else $error("pin 0 loss of lock second pll wrong");
  mode_gate_a: assert property (
    s_q.dir[0] |=> s_q.readback[0] == 1'b0 && clockOutputEnable[0] == $past(outEnableReg[0]))
    else $error("input function active in output mode");
  input_idle_a: assert property (
    !s_q.dir[3] |=> gpioOut[3] == 1'b0 && gpioOe[3] == 1'b0)
    else $error("output function active in input mode");
  en_off_a: assert property (
    !outEnableReg[6] |=> !clockOutputEnable[6])
    else $error("clock output enabled while register enable low");

  // ------------------------------------------------------------
  // register bus checks
  // ------------------------------------------------------------
  // direction register reads back what was written
  dir_read_a: assert property (
    regReq.rd && regReq.addr == DIR_OFS |=> regRdata == {4'h0, $past(s_q.dir)})
    else $error("direction register read wrong");
  // output value register takes the low nibble of a write
  outval_write_a: assert property (
    regReq.wr && regReq.addr == OVAL_OFS |=> s_q.outVal == $past(regReq.wdata[3:0]))
    else $error("output value register write lost");
  // reserved byte always reads zero
  rsvd_read_a: assert property (
    regReq.rd && regReq.addr == RSVD_OFS |=> regRdata == 8'h00)
    else $error("reserved byte read not zero");
  // reserved upper bits of every register read zero
  upper_zero_a: assert property (
    regReq.rd |=> regRdata[7:4] == 4'h0)
    else $error("reserved read bits not zero");
  // read data stands only in the cycle after the strobe
  rdata_pulse_a: assert property (
    !regReq.rd |=> regRdata == 8'h00)
    else $error("read data outside the answer cycle");

  // ------------------------------------------------------------
  // output-enable gating and reference select per pin
  // ------------------------------------------------------------
  // pin 0 code 001 gates clock output 0
  oe_pin0_a: assert property (
    !s_q.dir[0] && pin0In == FN_SEL_A |=> clockOutputEnable[0] ==
    ($past(outEnableReg[0]) & $past(s_q.syncB[0])))
    else $error("pin 0 does not gate clock output 0");
  // pin 1 code 001 gates clock output 1
  oe_pin1_a: assert property (
    !s_q.dir[1] && pin1In == FN_SEL_A |=> clockOutputEnable[1] ==
    ($past(outEnableReg[1]) & $past(s_q.syncB[1])))
    else $error("pin 1 does not gate clock output 1");
  // pin 1 code 010 gates clock output 5
  oe_pin1b_a: assert property (
    !s_q.dir[1] && pin1In == FN_SEL_B |=> clockOutputEnable[5] ==
    ($past(outEnableReg[5]) & $past(s_q.syncB[1])))
    else $error("pin 1 does not gate clock output 5");
  // pin 2 code 001 gates clock output 2
  oe_pin2_a: assert property (
    !s_q.dir[2] && pin2In == FN_SEL_A |=> clockOutputEnable[2] ==
    ($past(outEnableReg[2]) & $past(s_q.syncB[2])))
    else $error("pin 2 does not gate clock output 2");
  // pin 2 code 010 gates clock output 6
  oe_pin2b_a: assert property (
    !s_q.dir[2] && pin2In == FN_SEL_B |=> clockOutputEnable[6] ==
    ($past(outEnableReg[6]) & $past(s_q.syncB[2])))
    else $error("pin 2 does not gate clock output 6");
  // pin 3 code 001 gates clock output 3
  oe_pin3_a: assert property (
    !s_q.dir[3] && pin3In == FN_SEL_A |=> clockOutputEnable[3] ==
    ($past(outEnableReg[3]) & $past(s_q.syncB[3])))
    else $error("pin 3 does not gate clock output 3");
  // pin 3 code 010 gates clock output 7
  oe_pin3b_a: assert property (
    !s_q.dir[3] && pin3In == FN_SEL_B |=> clockOutputEnable[7] ==
    ($past(outEnableReg[7]) & $past(s_q.syncB[3])))
    else $error("pin 3 does not gate clock output 7");
  // pin 3 code 101 steers the second pll reference select
  ref_second_a: assert property (
    !s_q.dir[3] && pin3In == FN_REF_SEL |=> refSelect.active[1] &&
    refSelect.level[1] == $past(s_q.syncB[3]))
    else $error("second reference select not routed");
  // without code 101 the second select is released
  ref_idle_a: assert property (
    !(!s_q.dir[3] && pin3In == FN_REF_SEL) |=> !refSelect.active[1] && !refSelect.level[1])
    else $error("second reference select driven without its code");

  // ------------------------------------------------------------
  // status flags on output pins
  // ------------------------------------------------------------
  // pin 0 code 001 shows loss of lock of the first pll
  lol_first_a: assert property (
    s_q.dir[0] && pin0Out == FN_SEL_A |=> gpioOut[0] == $past(statusFlags.lossOfLock[0]))
    else $error("pin 0 loss of lock first pll wrong");
  // pin 1 code 001 shows holdover of the first pll
  hold_first_a: assert property (
    s_q.dir[1] && pin1Out == FN_SEL_A |=> gpioOut[1] == $past(statusFlags.holdover[0]))
    else $error("pin 1 holdover first pll wrong");
  // pin 1 code 010 shows holdover of the second pll
  hold_second_a: assert property (
    s_q.dir[1] && pin1Out == FN_SEL_B |=> gpioOut[1] == $past(statusFlags.holdover[1]))
    else $error("pin 1 holdover second pll wrong");
  // pin 2 code 001 shows loss of signal of reference 0
  los_ref0_a: assert property (
    s_q.dir[2] && pin2Out == FN_SEL_A |=> gpioOut[2] == $past(statusFlags.lossOfSignal[0]))
    else $error("pin 2 loss of signal ref 0 wrong");
  // pin 2 code 010 shows loss of signal of reference 1
  los_ref1_a: assert property (
    s_q.dir[2] && pin2Out == FN_SEL_B |=> gpioOut[2] == $past(statusFlags.lossOfSignal[1]))
    else $error("pin 2 loss of signal ref 1 wrong");
  // pin 3 code 001 shows loss of lock of the second pll
  lol_pin3_a: assert property (
    s_q.dir[3] && pin3Out == FN_SEL_A |=> gpioOut[3] == $past(statusFlags.lossOfLock[1]))
    else $error("pin 3 loss of lock second pll wrong");
  // pin 3 code 010 shows loss of signal of reference 1
  los_pin3_a: assert property (
    s_q.dir[3] && pin3Out == FN_SEL_B |=> gpioOut[3] == $past(statusFlags.lossOfSignal[1]))
    else $error("pin 3 loss of signal ref 1 wrong");

  // ------------------------------------------------------------
  // direction and mode separation
  // ------------------------------------------------------------
  // pin 3 general output follows the value register
  gp_pin3_a: assert property (
    s_q.dir[3] && pin3Out == FN_GENERAL |=> gpioOut[3] == $past(s_q.outVal[3]))
    else $error("pin 3 general output value not driven");
  // pin 1 general output follows the value register
  gp_pin1_a: assert property (
    s_q.dir[1] && pin1Out == FN_GENERAL |=> gpioOut[1] == $past(s_q.outVal[1]))
    else $error("pin 1 general output value not driven");
  // pin 2 in output mode leaves its gates and select alone
  out_mode_a: assert property (
    s_q.dir[2] |=> clockOutputEnable[2] == $past(outEnableReg[2]) &&
    clockOutputEnable[6] == $past(outEnableReg[6]) && !refSelect.active[0])
    else $error("pin 2 input function active in output mode");
  // pin 1 as input neither drives nor enables its pad
  idle_pin1_a: assert property (
    !s_q.dir[1] |=> gpioOut[1] == 1'b0 && gpioOe[1] == 1'b0)
    else $error("pin 1 output function active in input mode");
  // pin 1 as input with a control code reads back zero
  rb_code_a: assert property (
    !s_q.dir[1] && pin1In != FN_GENERAL |=> !s_q.readback[1])
    else $error("readback set for a pin with a control code");

  // ------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------
  // main scenarios reached by the bench
  gp_read_c: cover property (regReq.rd && regReq.addr == RDBK_OFS ##1 regRdata != 8'h00);
  gate_b_c: cover property (!s_q.dir[2] && pin2In == FN_SEL_B ##1 !clockOutputEnable[6]);
  oe_ctrl_c: cover property (!s_q.dir[1] && s_q.isel0[1] ##1 !clockOutputEnable[1]);
  flag_out_c: cover property (s_q.dir[3] && s_q.osel1[3] ##1 gpioOut[3]);
  ref_sel_c: cover property (refSelect.active[1] && refSelect.level[1]);
endmodule

// >>> pin_board.sv
module pin_board (
  input wire logic [3:0] boardLevel,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] gpioOe,
  output logic [3:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  // wire level: device where enabled, board logic elsewhere
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pinLevel[p] = gpioOe[p] ? gpioOut[p] : boardLevel[p];
    end
  end
endmodule

// >>> testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_mux_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int FA[4] = '{4, 2, 0, 5};
  localparam int FB[4] = '{5, 3, 1, 1};
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_t regReq = '0;
  logic [7:0] regRdata;
  logic [3:0] gpioOut;
  logic [3:0] gpioOe;
  logic [3:0] pinLevel;
  logic [3:0] boardLevel = 4'h0;
  status_flags_t statusFlags = '0;
  logic [7:0] outEnableReg = 8'h00;
  logic [7:0] clockOutputEnable;
  ref_select_t refSelect;
  int failures = 0;
  int cmp_count = 0;
  logic [3:0] dir;
  logic [3:0] oval;
  logic [2:0] isel [4];
  logic [2:0] osel [4];
  always #25 core_clk = ~core_clk;
  clock_chip_gpio_mux DUT (.core_clk(core_clk), .resetn(resetn), .regReq(regReq),
    .regRdata(regRdata), .gpioIn(pinLevel), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .statusFlags(statusFlags), .outEnableReg(outEnableReg),
    .clockOutputEnable(clockOutputEnable), .refSelect(refSelect));
  pin_board board (.boardLevel(boardLevel), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .pinLevel(pinLevel));
  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    @(negedge core_clk);
    chk(regRdata, exp);
  endtask
  // one register column: bit b of every pin code
  function automatic logic [7:0] col(input logic [2:0] c [4], input int b);
    return {4'h0, c[3][b], c[2][b], c[1][b], c[0][b]};
  endfunction
  task automatic check_pins();
    logic [3:0] rb;
    logic [3:0] go;
    logic [1:0] act;
    logic [7:0] gate;
    logic [5:0] f;
    rb = 4'h0;
    go = 4'h0;
    act = 2'h0;
    gate = 8'hff;
    f = statusFlags;
    for (int p = 0; p < 4; p++) begin
      if (!dir[p]) begin
        rb[p] = (isel[p] == FN_GENERAL) ? boardLevel[p] : 1'b0;
        if (isel[p] == FN_SEL_A) gate[p] = boardLevel[p];
        if (isel[p] == FN_SEL_B) gate[p+4] = boardLevel[p];
        if (p > 1 && isel[p] == FN_REF_SEL) act[p-2] = 1'b1;
      end else begin
        go[p] = (osel[p] == FN_GENERAL) ? oval[p] : f[(osel[p] == FN_SEL_A) ? FA[p] : FB[p]];
      end
    end
    chk({4'h0, gpioOe}, {4'h0, dir});
    chk({4'h0, gpioOut}, {4'h0, go});
    chk(clockOutputEnable, outEnableReg & gate);
    chk({4'h0, refSelect.level, refSelect.active},
        {4'h0, act & boardLevel[3:2], act});
    rd(RDBK_OFS, {4'h0, rb});
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd374));
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    // reset values, reserved byte and an unmapped address
    for (int i = 0; i < 9; i++) begin
      rd(DIR_OFS + 10'(i), 8'h00);
    end
    rd(RDBK_OFS, 8'h00);
    wr(RSVD_OFS, 8'h00);
    rd(10'h100, 8'h00);
    for (int it = 0; it < 40; it++) begin
      dir = (it == 0) ? 4'h0 : (it == 1) ? 4'hf : 4'($urandom);
      oval = 4'($urandom);
      // legal codes only; pins 2 and 3 also take the reference select
      for (int p = 0; p < 4; p++) begin
        isel[p] = 3'($urandom % 3);
        if (p > 1 && $urandom % 4 == 0) isel[p] = FN_REF_SEL;
        osel[p] = 3'($urandom % 3);
      end
      wr(DIR_OFS, {4'h0, dir});
      for (int b = 0; b < 3; b++) begin
        wr(ISEL2_OFS + 10'(b), col(isel, 2 - b));
        wr(OSEL2_OFS + 10'(b), col(osel, 2 - b));
      end
      wr(OVAL_OFS, {4'h0, oval});
      rd(DIR_OFS, {4'h0, dir});
      for (int b = 0; b < 3; b++) begin
        rd(ISEL2_OFS + 10'(b), col(isel, 2 - b));
        rd(OSEL2_OFS + 10'(b), col(osel, 2 - b));
      end
      rd(OVAL_OFS, {4'h0, oval});
      @(posedge core_clk);
      boardLevel <= 4'($urandom);
      statusFlags <= status_flags_t'(6'($urandom));
      outEnableReg <= 8'($urandom);
      // synchroniser and output register settle
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      check_pins();
    end
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_sim();
  end
endmodule
